// ---- hdl/ufb_pkg.sv ----
// Shared constants and types of the fractional-baud serial port core.
// Functional notes
// - Transmit and receive enables gate each direction; both set after reset.
// - Clearing the port enable mid-character lets that character finish first.
// - Transmit start bit, data LSB first, optional parity, then stop bits.
// - Receiver flags overrun, parity, framing and break, stored with each character.
// - Baud divisor is 22 bits: 16-bit whole part plus 6-bit fraction.
// - Oversample tick at sixteen times baud times transmit bits and receive sampling.
// - Divisors and line settings form a 30-bit shadow loaded on line write only.
// - Sixteen-entry transmit and receive queues; receive entries carry four status bits.
// - Queued byte starts a frame while enabled; frames run back to back.
// - Busy rises on non-empty queue, falls after last stop bit leaves.
// - Low line from idle starts counting; start bit confirmed low at eighth tick.
// - Data bits sampled every sixteenth tick for the set length, then parity checked.
// - Low stop sample is a framing error; character then pushed with its flags.
// - Character length is five, six, seven or eight bits both ways.
// - Parity is even, odd, stick or none for generation and checking.
// - Transmitter appends one or two stop bits as set.
package ufb_pkg;

	// ==========================================================
	// Register map and fields
	localparam logic [7:0] DATA_OFS = 8'h00;
	localparam logic [7:0] FLAG_OFS = 8'h18;
	localparam logic [7:0] IDIV_OFS = 8'h24;
	localparam logic [7:0] FDIV_OFS = 8'h28;
	localparam logic [7:0] LINE_OFS = 8'h2c;
	localparam logic [7:0] CTL_OFS  = 8'h30;
	localparam int CTL_PORT_BIT = 0;
	localparam int CTL_TX_BIT   = 8;
	localparam int CTL_RX_BIT   = 9;
	localparam logic CTL_PORT_RST = 1'b0;
	localparam logic CTL_TX_RST   = 1'b1;
	localparam logic CTL_RX_RST   = 1'b1;
	localparam int FLG_BUSY     = 3;
	localparam int FLG_RX_EMPTY = 4;
	localparam int FLG_TX_FULL  = 5;
	localparam int FLG_RX_FULL  = 6;
	localparam int FLG_TX_EMPTY = 7;
	localparam logic [15:0] IDIV_RST = 16'h0000;
	localparam logic [5:0]  FDIV_RST = 6'h00;
	localparam logic [7:0]  LINE_RST = 8'h00;

	// ==========================================================
	// Queues and timing
	localparam int FIFO_AW    = 4;
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_MID  = 4'h7;

	// ==========================================================
	// Types
	typedef enum logic [4:0] {
		PH_IDLE  = 5'b00001,
		PH_START = 5'b00010,
		PH_DATA  = 5'b00100,
		PH_PAR   = 5'b01000,
		PH_STOP  = 5'b10000
	} ufb_phase_e;

	typedef struct packed {
		logic       stick;
		logic [1:0] wlen;
		logic       fifo_on;
		logic       stop2;
		logic       even;
		logic       par_en;
		logic       brk;
	} ufb_line_s;

	typedef struct packed {
		logic [15:0] div_int;
		logic [5:0]  div_frac;
		ufb_line_s   line;
	} ufb_shadow_s;

	typedef struct packed {
		logic       overrun;
		logic       brk;
		logic       parity_err;
		logic       frame_err;
		logic [7:0] data;
	} ufb_rx_entry_s;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ufb_bus_req_s;

endpackage

// ---- hdl/ufb_fifo.sv ----
// Sixteen-entry queue whose head is presented from a register.
`timescale 1ns/1ps
module ufb_fifo #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         push,
	input  wire logic [W-1:0] push_data,
	input  wire logic         pop,
	output logic      [W-1:0] head,
	output logic              avail,
	output logic              empty,
	output logic              full
);
	logic [W-1:0] mem [ufb_pkg::FIFO_DEPTH];
	logic [ufb_pkg::FIFO_AW-1:0] wr_ptr_q;
	logic [ufb_pkg::FIFO_AW-1:0] rd_ptr_q;
	logic [ufb_pkg::FIFO_AW:0]   count_q;
	logic do_push;
	logic do_pop;

	assign empty   = (count_q == '0);
	assign full    = (count_q == (ufb_pkg::FIFO_AW+1)'(ufb_pkg::FIFO_DEPTH));
	assign do_push = push && !full;
	assign do_pop  = pop && avail;

	always_ff @(posedge sys_clk) begin
		if (do_push) begin
			mem[wr_ptr_q] <= push_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (do_push) wr_ptr_q <= wr_ptr_q + 1'b1;
			if (do_pop) rd_ptr_q <= rd_ptr_q + 1'b1;
			count_q <= count_q + {4'h0, do_push} - {4'h0, do_pop};
		end
	end

	// The head lags the pointer by one cycle, so avail is withheld for that cycle.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			head  <= '0;
			avail <= 1'b0;
		end else begin
			head  <= mem[rd_ptr_q];
			avail <= !empty && !pop;
		end
	end

	a_fifo_count_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
		full && push && !pop |=> full)
		else $error("queue count moved past its depth");
endmodule

// ---- hdl/ufb_baud.sv ----
// Fractional divider making the sixteen-times oversample tick.
`timescale 1ns/1ps
module ufb_baud (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic [15:0] div_int,
	input  wire logic [5:0]  div_frac,
	output logic             tick
);
	logic [15:0] cnt_q;
	logic [5:0]  acc_q;
	logic [6:0]  sum;
	logic [15:0] div_eff;

	// A zero whole part would never tick; it is treated as one.
	assign div_eff = (div_int == 16'h0000) ? 16'h0001 : div_int;
	assign sum     = {1'b0, acc_q} + {1'b0, div_frac};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 16'h0000;
			acc_q <= 6'h00;
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_q <= 16'h0000;
			acc_q <= 6'h00;
			tick  <= 1'b0;
		end else if (cnt_q == 16'h0000) begin
			tick  <= 1'b1;
			acc_q <= sum[5:0];
			cnt_q <= div_eff - 16'h0001 + {15'h0000, sum[6]};
		end else begin
			tick  <= 1'b0;
			cnt_q <= cnt_q - 16'h0001;
		end
	end

	a_baud_gap_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
		tick && run && $stable(div_int) && div_int >= 16'h0003 |=> !tick ##1 !tick)
		else $error("oversample ticks closer than the whole divisor");
endmodule

// ---- hdl/ufb_uart_core.sv ----
// Serial port core: register port, transmit and receive engines and queues.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
module ufb_uart_core (
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	input  wire ufb_pkg::ufb_bus_req_s bus,
	output logic [31:0]                rd_data,
	input  wire logic                  serial_in,
	output logic                       serial_out
);
	// ==========================================================
	// Reset and input synchronisers
	logic rst_s1_q;
	logic rst_n_q;
	logic rx_s1_q;
	logic rx_in;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_s1_q <= 1'b1;
			rx_in   <= 1'b1;
		end else begin
			rx_s1_q <= serial_in;
			rx_in   <= rx_s1_q;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n_q);

	// ==========================================================
	// Register port
	logic                 port_on_q;
	logic                 transmit_path_on_q;
	logic                 receive_path_on_q;
	logic [15:0]          integer_divisor_q;
	logic [5:0]           fraction_divisor_q;
	ufb_pkg::ufb_shadow_s shadow_q;
	ufb_pkg::ufb_line_s   line;
	logic                 wr_data;
	logic                 wr_line;
	logic                 rd_data_sel;
	logic [7:0]           flags;
	logic                 busy;
	logic                 tx_empty;
	logic                 tx_full;
	logic                 tx_avail;
	logic [7:0]           tx_head;
	logic                 rx_empty;
	logic                 rx_full;
	logic                 rx_avail;
	ufb_pkg::ufb_rx_entry_s rx_head;

	assign line        = shadow_q.line;
	assign wr_data     = bus.wr && (bus.addr == ufb_pkg::DATA_OFS);
	assign wr_line     = bus.wr && (bus.addr == ufb_pkg::LINE_OFS);
	assign rd_data_sel = bus.rd && (bus.addr == ufb_pkg::DATA_OFS);

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			port_on_q          <= ufb_pkg::CTL_PORT_RST;
			transmit_path_on_q <= ufb_pkg::CTL_TX_RST;
			receive_path_on_q  <= ufb_pkg::CTL_RX_RST;
		end else if (bus.wr && bus.addr == ufb_pkg::CTL_OFS) begin
			port_on_q          <= bus.wdata[ufb_pkg::CTL_PORT_BIT];
			transmit_path_on_q <= bus.wdata[ufb_pkg::CTL_TX_BIT];
			receive_path_on_q  <= bus.wdata[ufb_pkg::CTL_RX_BIT];
		end
	end

	// Divisor writes only stage; the line write moves them into the shadow at once.
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			integer_divisor_q  <= ufb_pkg::IDIV_RST;
			fraction_divisor_q <= ufb_pkg::FDIV_RST;
			shadow_q           <= {ufb_pkg::IDIV_RST, ufb_pkg::FDIV_RST, ufb_pkg::LINE_RST};
		end else begin
			if (bus.wr && bus.addr == ufb_pkg::IDIV_OFS) begin
				integer_divisor_q <= bus.wdata[15:0];
			end
			if (bus.wr && bus.addr == ufb_pkg::FDIV_OFS) begin
				fraction_divisor_q <= bus.wdata[5:0];
			end
			if (wr_line) begin
				shadow_q <= {integer_divisor_q, fraction_divisor_q, bus.wdata[7:0]};
			end
		end
	end

	always_comb begin
		flags = 8'h00;
		flags[ufb_pkg::FLG_BUSY]     = busy;
		flags[ufb_pkg::FLG_RX_EMPTY] = rx_empty;
		flags[ufb_pkg::FLG_TX_FULL]  = tx_full;
		flags[ufb_pkg::FLG_RX_FULL]  = rx_full;
		flags[ufb_pkg::FLG_TX_EMPTY] = tx_empty;
	end

	// Read data stand for exactly the cycle after the strobe and are zero otherwise.
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rd_data <= 32'h0000_0000;
		end else if (!bus.rd) begin
			rd_data <= 32'h0000_0000;
		end else begin
			case (bus.addr)
				ufb_pkg::DATA_OFS: rd_data <= rx_avail ? {20'h00000, rx_head} : 32'h0;
				ufb_pkg::FLAG_OFS: rd_data <= {24'h000000, flags};
				ufb_pkg::IDIV_OFS: rd_data <= {16'h0000, integer_divisor_q};
				ufb_pkg::FDIV_OFS: rd_data <= {26'h0000000, fraction_divisor_q};
				ufb_pkg::LINE_OFS: rd_data <= {24'h000000, line};
				ufb_pkg::CTL_OFS: begin
					rd_data <= {22'h000000, receive_path_on_q, transmit_path_on_q,
						7'h00, port_on_q};
				end
				default: rd_data <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Oversample tick and shared parity
	logic tick;
	logic tx_idle;
	logic rx_idle;
	logic baud_run;

	// The divider keeps running while a character is in flight after the port is shut.
	assign baud_run = (port_on_q && (transmit_path_on_q || receive_path_on_q))
		|| !tx_idle || !rx_idle;

	ufb_baud u_baud (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n_q),
		.run      (baud_run),
		.div_int  (shadow_q.div_int),
		.div_frac (shadow_q.div_frac),
		.tick     (tick)
	);

	function automatic logic parity_of(input logic [7:0] d, input ufb_pkg::ufb_line_s l);
		logic [7:0] mask;
		mask = 8'hff >> (2'd3 - l.wlen);
		parity_of = l.stick ? !l.even : ((^(d & mask)) ^ !l.even);
	endfunction

	// ==========================================================
	// Transmit engine
	ufb_pkg::ufb_phase_e tx_st_q;
	logic [3:0] tx_sub_q;
	logic [2:0] tx_bit_q;
	logic [7:0] tx_sh_q;
	logic       tx_par_q;
	logic       tx_pend_q;
	logic       tx_out_q;
	logic       tx_start;
	logic       tx_bit_end;
	logic [2:0] last_bit;

	assign last_bit   = 3'd4 + {1'b0, line.wlen};
	assign tx_idle    = (tx_st_q == ufb_pkg::PH_IDLE);
	assign tx_bit_end = tick && (tx_sub_q == ufb_pkg::OVS_LAST);
	assign tx_start   = tx_idle && tx_avail && port_on_q && transmit_path_on_q;
	assign busy       = !tx_empty || !tx_idle;
	assign serial_out = tx_out_q && !line.brk;

	ufb_fifo #(.W(8)) u_tx_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n_q),
		.push      (wr_data),
		.push_data (bus.wdata[7:0]),
		.pop       (tx_start),
		.head      (tx_head),
		.avail     (tx_avail),
		.empty     (tx_empty),
		.full      (tx_full)
	);

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_sub_q <= 4'h0;
		end else if (tx_start) begin
			tx_sub_q <= 4'h0;
		end else if (tick) begin
			tx_sub_q <= tx_sub_q + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_st_q   <= ufb_pkg::PH_IDLE;
			tx_bit_q  <= 3'd0;
			tx_sh_q   <= 8'h00;
			tx_par_q  <= 1'b0;
			tx_pend_q <= 1'b0;
			tx_out_q  <= 1'b1;
		end else begin
			case (tx_st_q)
				ufb_pkg::PH_IDLE: begin
					if (tx_start) begin
						tx_st_q  <= ufb_pkg::PH_START;
						tx_sh_q  <= tx_head;
						tx_par_q <= parity_of(tx_head, line);
						tx_out_q <= 1'b0;
					end
				end
				ufb_pkg::PH_START: begin
					if (tx_bit_end) begin
						tx_st_q  <= ufb_pkg::PH_DATA;
						tx_bit_q <= 3'd0;
						tx_out_q <= tx_sh_q[0];
						tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
					end
				end
				ufb_pkg::PH_DATA: begin
					if (tx_bit_end && tx_bit_q == last_bit) begin
						tx_pend_q <= line.stop2;
						tx_st_q   <= line.par_en ? ufb_pkg::PH_PAR : ufb_pkg::PH_STOP;
						tx_out_q  <= line.par_en ? tx_par_q : 1'b1;
					end else if (tx_bit_end) begin
						tx_bit_q <= tx_bit_q + 3'd1;
						tx_out_q <= tx_sh_q[0];
						tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
					end
				end
				ufb_pkg::PH_PAR: begin
					if (tx_bit_end) begin
						tx_st_q  <= ufb_pkg::PH_STOP;
						tx_out_q <= 1'b1;
					end
				end
				ufb_pkg::PH_STOP: begin
					if (tx_bit_end && tx_pend_q) begin
						tx_pend_q <= 1'b0;
					end else if (tx_bit_end) begin
						tx_st_q <= ufb_pkg::PH_IDLE;
					end
				end
				default: tx_st_q <= ufb_pkg::PH_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receive engine
	ufb_pkg::ufb_phase_e    rx_st_q;
	logic [3:0]             rx_sub_q;
	logic [2:0]             rx_bit_q;
	logic [7:0]             rx_sh_q;
	logic                   rx_pe_q;
	logic                   rx_high_q;
	logic                   rx_armed_q;
	logic                   rx_ovr_q;
	logic                   rx_begin;
	logic                   rx_sample;
	logic                   rx_push;
	ufb_pkg::ufb_rx_entry_s rx_entry;

	assign rx_idle   = (rx_st_q == ufb_pkg::PH_IDLE);
	assign rx_begin  = rx_idle && rx_armed_q && !rx_in && port_on_q && receive_path_on_q;
	assign rx_sample = tick && (rx_sub_q == ufb_pkg::OVS_LAST);
	assign rx_push   = (rx_st_q == ufb_pkg::PH_STOP) && rx_sample;

	// A break holds every sample low, stop bit included.
	always_comb begin
		rx_entry.overrun    = rx_ovr_q;
		rx_entry.brk        = !rx_high_q && !rx_in;
		rx_entry.parity_err = rx_pe_q;
		rx_entry.frame_err  = !rx_in;
		rx_entry.data       = rx_sh_q;
	end

	ufb_fifo #(.W(12)) u_rx_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n_q),
		.push      (rx_push),
		.push_data (rx_entry),
		.pop       (rd_data_sel),
		.head      (rx_head),
		.avail     (rx_avail),
		.empty     (rx_empty),
		.full      (rx_full)
	);

	// A character that meets a full queue is dropped and marks the next one stored.
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_ovr_q <= 1'b0;
		end else if (rx_push) begin
			rx_ovr_q <= rx_full;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_sub_q <= 4'h0;
		end else if (rx_begin || (rx_st_q == ufb_pkg::PH_START && tick
				&& rx_sub_q == ufb_pkg::OVS_MID)) begin
			rx_sub_q <= 4'h0;
		end else if (tick) begin
			rx_sub_q <= rx_sub_q + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_st_q    <= ufb_pkg::PH_IDLE;
			rx_bit_q   <= 3'd0;
			rx_sh_q    <= 8'h00;
			rx_pe_q    <= 1'b0;
			rx_high_q  <= 1'b0;
			rx_armed_q <= 1'b0;
		end else begin
			case (rx_st_q)
				ufb_pkg::PH_IDLE: begin
					if (rx_in) begin
						rx_armed_q <= 1'b1;
					end
					if (rx_begin) begin
						rx_st_q    <= ufb_pkg::PH_START;
						rx_armed_q <= 1'b0;
					end
				end
				ufb_pkg::PH_START: begin
					if (tick && rx_sub_q == ufb_pkg::OVS_MID) begin
						rx_st_q   <= rx_in ? ufb_pkg::PH_IDLE : ufb_pkg::PH_DATA;
						rx_bit_q  <= 3'd0;
						rx_sh_q   <= 8'h00;
						rx_pe_q   <= 1'b0;
						rx_high_q <= 1'b0;
					end
				end
				ufb_pkg::PH_DATA: begin
					if (rx_sample) begin
						rx_sh_q[rx_bit_q] <= rx_in;
						rx_high_q         <= rx_high_q || rx_in;
						rx_bit_q          <= rx_bit_q + 3'd1;
						if (rx_bit_q == last_bit) begin
							rx_st_q <= line.par_en ? ufb_pkg::PH_PAR : ufb_pkg::PH_STOP;
						end
					end
				end
				ufb_pkg::PH_PAR: begin
					if (rx_sample) begin
						rx_pe_q   <= rx_in != parity_of(rx_sh_q, line);
						rx_high_q <= rx_high_q || rx_in;
						rx_st_q   <= ufb_pkg::PH_STOP;
					end
				end
				ufb_pkg::PH_STOP: begin
					if (rx_sample) begin
						rx_st_q <= ufb_pkg::PH_IDLE;
					end
				end
				default: rx_st_q <= ufb_pkg::PH_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Checks
	a_tx_gate_enables: assert property (
		tx_idle ##1 !tx_idle |-> $past(port_on_q && transmit_path_on_q))
		else $error("transmitter left idle while gated off");

	a_tx_finish_char: assert property (
		!tx_idle && !port_on_q && tx_st_q != ufb_pkg::PH_STOP |=> !tx_idle)
		else $error("character abandoned after port was shut");

	a_tx_start_low: assert property (
		tx_idle ##1 !tx_idle |-> !tx_out_q && tx_sub_q == 4'h0)
		else $error("frame did not open with a low start bit");

	a_shadow_only_line: assert property (
		!$stable(shadow_q) |-> $past(wr_line))
		else $error("shadow changed without a line write");

	a_busy_fall_end: assert property (
		$fell(busy) |-> $past(tx_st_q) == ufb_pkg::PH_STOP && tx_empty)
		else $error("busy fell before last stop bit left");

	a_rx_start_reject: assert property (
		rx_st_q == ufb_pkg::PH_START && tick && rx_sub_q == ufb_pkg::OVS_MID && rx_in
		|=> rx_idle)
		else $error("high mid-start sample was not rejected");

	a_rx_push_once: assert property (
		rx_push |=> rx_idle && !rx_push)
		else $error("receive push did not end the character");

	a_tx_stop_high: assert property (
		tx_st_q == ufb_pkg::PH_STOP |-> tx_out_q)
		else $error("stop bit driven low");
endmodule

// ---- tb/ufb_remote.sv ----
// Behavioural far-side serial device for the serial port core bench.
`timescale 1ns/1ps
module ufb_remote (
	input  wire logic sys_clk,
	input  wire logic line_in,
	output logic      line_out
);
	// ==========================================================
	// Bit timing, changed by the bench when the divisor changes.
	int bit_cyc = 32;

	initial line_out = 1'b1;

	// Bits go out LSB first; the line rests high after the last one.
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			line_out <= bits[i];
			repeat (bit_cyc) @(posedge sys_clk);
		end
		line_out <= 1'b1;
	endtask

	// A short low pulse that a receiver must reject at its mid-start sample.
	task automatic glitch(input int n);
		line_out <= 1'b0;
		repeat (n) @(posedge sys_clk);
		line_out <= 1'b1;
	endtask

	// Samples mid-bit; a start bit that is no longer low leaves the bits above the n sampled ones high.
	task automatic recv(input int n, output logic [11:0] bits);
		bits = '0;
		@(negedge line_in);
		repeat (bit_cyc / 2) @(posedge sys_clk);
		if (line_in !== 1'b0) bits = 12'hfff;
		for (int i = 0; i < n; i++) begin
			repeat (bit_cyc) @(posedge sys_clk);
			bits[i] = line_in;
		end
	endtask
endmodule

// ---- tb/ufb_uart_core_tb_top.sv ----
// Self-checking bench for the serial port core.
`timescale 1ns/1ps
module ufb_uart_core_tb_top;
	logic                  sys_clk;
	logic                  nrst;
	ufb_pkg::ufb_bus_req_s bus;
	logic [31:0]           rd_data;
	logic                  serial_in;
	logic                  serial_out;
	int                    n_mismatch = 0;
	int                    checked = 0;
	logic [11:0]           got;
	logic [11:0]           f;
	logic [11:0]           e;
	logic [7:0]            ln;
	logic [7:0]            d2;
	logic [1:0]            kind;
	logic                  low;
	// Kind in the top bits: 0 clean, 1 bad parity, 2 low stop, 3 line break.
	logic [9:0]            modes [8] = '{10'h060, 10'h000, 10'h02a, 10'h046,
	                                     10'h0e2, 10'h1e6, 10'h260, 10'h360};

	ufb_uart_core u_dut (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rd_data(rd_data),
	                     .serial_in(serial_in), .serial_out(serial_out));
	ufb_remote u_rem (.sys_clk(sys_clk), .line_in(serial_out), .line_out(serial_in));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// Register access and comparison
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus <= '0;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus <= '0;
		@(negedge sys_clk);
		v = rd_data;
		chk(v, exp);
	endtask

	function automatic int nb(input logic [7:0] l);
		return int'(l[6:5]) + 6 + int'(l[1]) + int'(l[3]);
	endfunction

	// Expected frame after the start bit: data, parity, stop bits.
	function automatic logic [11:0] frm(input logic [7:0] d, input logic [7:0] l, input logic stp);
		logic [11:0] r;
		int          n;
		n = int'(l[6:5]) + 5;
		r = {4'h0, d & (8'hff >> (8 - n))};
		if (l[1]) begin
			r[n] = l[7] ? ~l[2] : (^r[7:0]) ^ ~l[2];
			n++;
		end
		r[n] = stp;
		if (l[3]) r[n + 1] = 1'b1;
		return r;
	endfunction

	task automatic txchk(input logic [7:0] d, input logic [7:0] l);
		fork
			u_rem.recv(nb(l), got);
			wr(ufb_pkg::DATA_OFS, {24'h0, d});
		join
		chk(got, frm(d, l, 1'b1));
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		n_mismatch++;
		print_verdict();
	end

	// ==========================================================
	// Scenarios
	initial begin
		nrst = 1'b0;
		bus = '0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rchk(ufb_pkg::CTL_OFS, 32'h300);
		rchk(ufb_pkg::LINE_OFS, 32'h0);
		rchk(ufb_pkg::FLAG_OFS, 32'h90);
		rchk(8'h3c, 32'h0);
		$display("test reset done");

		// Port stays off while the queue is filled past its depth.
		wr(ufb_pkg::IDIV_OFS, 32'h2);
		wr(ufb_pkg::FDIV_OFS, 32'h0);
		wr(ufb_pkg::LINE_OFS, 32'h60);
		rchk(ufb_pkg::LINE_OFS, 32'h60);
		for (int i = 0; i < 17; i++) wr(ufb_pkg::DATA_OFS, 32'h30 + i);
		rchk(ufb_pkg::FLAG_OFS, 32'h38);
		chk(serial_out, 1'b1);
		wr(ufb_pkg::CTL_OFS, 32'h301);
		fork
			u_rem.recv(9, got);
			begin
				repeat (150) @(posedge sys_clk);
				wr(ufb_pkg::CTL_OFS, 32'h300);
			end
		join
		chk(got, 12'h130);
		low = 1'b0;
		repeat (700) begin
			@(posedge sys_clk);
			if (serial_out !== 1'b1) low = 1'b1;
		end
		chk(low, 1'b0);
		rchk(ufb_pkg::FLAG_OFS, 32'h18);
		wr(ufb_pkg::CTL_OFS, 32'h301);
		for (int i = 1; i < 16; i++) begin
			u_rem.recv(9, got);
			chk(got, 12'h100 | (12'h30 + i));
		end
		repeat (200) @(posedge sys_clk);
		rchk(ufb_pkg::FLAG_OFS, 32'h90);
		$display("test queue done");

		// A divisor write alone must leave the bit time alone.
		wr(ufb_pkg::CTL_OFS, 32'h300);
		wr(ufb_pkg::IDIV_OFS, 32'h3);
		rchk(ufb_pkg::IDIV_OFS, 32'h3);
		wr(ufb_pkg::CTL_OFS, 32'h301);
		txchk(8'hc3, 8'h60);
		wr(ufb_pkg::CTL_OFS, 32'h300);
		wr(ufb_pkg::FDIV_OFS, 32'h20);
		wr(ufb_pkg::LINE_OFS, 32'h60);
		u_rem.bit_cyc = 56;
		wr(ufb_pkg::CTL_OFS, 32'h301);
		txchk(8'h3c, 8'h60);
		wr(ufb_pkg::CTL_OFS, 32'h300);
		wr(ufb_pkg::IDIV_OFS, 32'h2);
		wr(ufb_pkg::FDIV_OFS, 32'h0);
		u_rem.bit_cyc = 32;
		$display("test divisor done");

		for (int i = 0; i < 8; i++) begin
			ln = modes[i][7:0];
			kind = modes[i][9:8];
			d2 = 8'ha5 ^ 8'(i * 37);
			wr(ufb_pkg::CTL_OFS, 32'h300);
			wr(ufb_pkg::LINE_OFS, {24'h0, ln});
			wr(ufb_pkg::CTL_OFS, 32'h301);
			txchk(8'h5a ^ 8'(i), ln);
			f = frm(d2, ln, kind != 2'd2);
			if (kind == 2'd1) f = f ^ (12'h1 << (int'(ln[6:5]) + 5));
			if (kind == 2'd3) f = 12'h0;
			e = frm(d2, ln & 8'h60, 1'b0) & 12'h0ff;
			e[9] = (kind == 2'd1);
			e[8] = (kind == 2'd2);
			if (kind == 2'd3) e = 12'h500;
			u_rem.send({f[10:0], 1'b0}, nb(ln) + 1);
			rchk(ufb_pkg::DATA_OFS, {20'h0, e});
		end
		$display("test modes done");

		// Seventeen characters meet sixteen free entries; the next stored one is marked.
		for (int i = 0; i < 17; i++) begin
			u_rem.send({3'h7, 8'h40 + 8'(i), 1'b0}, 10);
			repeat (4) @(posedge sys_clk);
		end
		rchk(ufb_pkg::FLAG_OFS, 32'hc0);
		for (int i = 0; i < 16; i++) rchk(ufb_pkg::DATA_OFS, 32'h40 + i);
		u_rem.send(12'hed4, 10);
		repeat (4) @(posedge sys_clk);
		rchk(ufb_pkg::DATA_OFS, 32'h86a);
		$display("test overrun done");

		// Each direction is gated alone; a held byte leaves once its path opens.
		wr(ufb_pkg::CTL_OFS, 32'h300);
		wr(ufb_pkg::CTL_OFS, 32'h101);
		u_rem.send(12'hed4, 10);
		rchk(ufb_pkg::DATA_OFS, 32'h0);
		wr(ufb_pkg::CTL_OFS, 32'h300);
		wr(ufb_pkg::CTL_OFS, 32'h201);
		wr(ufb_pkg::DATA_OFS, 32'h77);
		repeat (100) @(negedge sys_clk);
		chk(serial_out, 1'b1);
		rchk(ufb_pkg::FLAG_OFS, 32'h18);
		wr(ufb_pkg::CTL_OFS, 32'h300);
		wr(ufb_pkg::LINE_OFS, 32'h61);
		@(negedge sys_clk);
		chk(serial_out, 1'b0);
		wr(ufb_pkg::LINE_OFS, 32'h60);
		fork
			u_rem.recv(9, got);
			wr(ufb_pkg::CTL_OFS, 32'h301);
		join
		chk(got, 12'h177);
		u_rem.glitch(4);
		repeat (40) @(posedge sys_clk);
		rchk(ufb_pkg::DATA_OFS, 32'h0);
		$display("test gating done");
		print_verdict();
	end
endmodule
